// ==== base_clock_select_pll_control.sv ====
// How it works
// - select 1 gives vco/3, 0 gives osc/2
// - switch completes quickly, output held static meanwhile
// - select cannot be set while power bit clear
// - power bit cannot clear while select set
// - one write cannot change power and select
// - zero linear multiplier disables pll, forces oscillator
// - base clock 50 percent duty, half the oscillator or a third of the vco
// - irq enable writable only in automatic mode
// - lock change flag sets on every lock toggle
// - irq while flag and enable both set
// - manual mode: flag reads zero, no irq
// - reading control register clears lock change flag
// - power bit writable, enables vco, resets set
// - prescale field resets zero, locked while pll on
// - vco range field resets zero, locked while on
// - pll reference is buffered oscillator clock
// - automatic bandwidth bit, reset to manual
// - writing zero multiplier clears select; multiplier writes ignored while power bit set
`default_nettype none

module base_clock_select_pll_control
    import clock_gen_pkg::*;
(
    // system
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // clocks and lock detector, sampled on aclk
    input wire logic osc_clock,
    input wire logic vco_clock,
    input wire logic lock_detect,
    // clock generator outputs
    output logic base_clock_out,
    output logic pll_ref_clock,
    output logic switch_busy,
    output logic pll_irq,
    // settings for the analog loop
    output logic pll_enable,
    output logic [1:0] prescale_exponent,
    output logic [1:0] vco_range_exponent,
    output logic [7:0] vco_linear_multiplier
);

    function automatic logic [1:0] reg_select(input logic [31:0] addr);
        logic [31:0] word;
        word = {addr[31:2], 2'h0};
        if (word == ADDR_PLL_CONTROL)
            reg_select = SEL_PLL_CONTROL;
        else if (word == ADDR_BANDWIDTH_CONTROL)
            reg_select = SEL_BANDWIDTH_CONTROL;
        else if (word == ADDR_VCO_LINEAR_MULTIPLIER)
            reg_select = SEL_VCO_LINEAR_MULTIPLIER;
        else
            reg_select = SEL_NONE;
    endfunction

    // register state
    logic pll_power_on;
    logic base_clock_select;
    logic lock_irq_enable;
    logic lock_change_flag;
    logic auto_bandwidth;
    logic lock_q;

    // write channel holding
    logic aw_held;
    logic w_held;
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb_lo_q;

    // write decode
    wire logic do_write = aw_held & w_held & ~bvalid;
    wire logic [1:0] wr_sel = reg_select(awaddr_q);
    wire logic wr_ok = do_write & wstrb_lo_q;
    wire logic wr_ctl = wr_ok & (wr_sel == SEL_PLL_CONTROL);
    wire logic wr_bw = wr_ok & (wr_sel == SEL_BANDWIDTH_CONTROL);
    wire logic wr_mul = wr_ok & (wr_sel == SEL_VCO_LINEAR_MULTIPLIER) & ~pll_power_on;
    // unmapped writes answer with an error and change nothing
    wire logic [1:0] wr_resp = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;

    // read decode
    wire logic rd_take = arvalid & arready;
    wire logic [1:0] rd_sel = reg_select(araddr);
    wire logic rd_ctl = rd_take & (rd_sel == SEL_PLL_CONTROL);

    // control write interlocks, judged on the values held before the write
    wire logic wd_power = wdata_q[BIT_PLL_POWER_ON];
    wire logic wd_select = wdata_q[BIT_BASE_CLOCK_SELECT];
    wire logic multiplier_zero = (vco_linear_multiplier == 8'h00);
    wire logic power_request = wd_power | base_clock_select;
    wire logic power_changes = (power_request != pll_power_on);
    wire logic select_request = wd_select & pll_power_on & ~multiplier_zero;
    wire logic mul_write_zero = wr_mul & (wdata_q[7:0] == 8'h00);

    wire logic next_power = wr_ctl ? power_request : pll_power_on;
    wire logic next_select = mul_write_zero ? 1'h0 :
        (wr_ctl & ~power_changes) ? select_request : base_clock_select;
    wire logic next_irq_enable = (wr_ctl & auto_bandwidth) ?
        wdata_q[BIT_LOCK_IRQ_ENABLE] : lock_irq_enable;
    // a lock toggle in the same cycle as the clearing read wins
    wire logic next_flag = (lock_detect ^ lock_q) | (lock_change_flag & ~rd_ctl);

    // read data
    // the flag is shown as it stood before the clearing read lands
    wire logic [7:0] ctl_view = {lock_irq_enable & auto_bandwidth,
        lock_change_flag & auto_bandwidth,
        pll_power_on, base_clock_select, prescale_exponent, vco_range_exponent};
    wire logic [7:0] bw_view = {auto_bandwidth, lock_q & auto_bandwidth, 6'h00};
    wire logic [7:0] rd_view = (rd_sel == SEL_PLL_CONTROL) ? ctl_view :
        (rd_sel == SEL_BANDWIDTH_CONTROL) ? bw_view :
        (rd_sel == SEL_VCO_LINEAR_MULTIPLIER) ? vco_linear_multiplier : 8'h00;
    wire logic [1:0] rd_resp = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;

    // clock path
    wire logic osc_div;
    wire logic vco_div;
    // gated again here so a zero multiplier can never hand the vco through
    wire logic select_effective = base_clock_select & ~multiplier_zero;

    clock_edge_divider #(.EDGES(OSC_DIV_EDGES)) osc_divider
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .src_clock(osc_clock),
        .div_clock(osc_div)
    );

    clock_edge_divider #(.EDGES(VCO_DIV_EDGES)) vco_divider
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .src_clock(vco_clock),
        .div_clock(vco_div)
    );

    // both dividers count every source edge, giving even duty
    base_clock_switch clock_switch
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .select_vco(select_effective),
        .osc_div(osc_div),
        .vco_div(vco_div),
        .clock_out(base_clock_out),
        .busy(switch_busy)
    );

    // write address and data, taken in either order, one write at a time
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'h1;
            wready <= 1'h1;
            aw_held <= 1'h0;
            w_held <= 1'h0;
            awaddr_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            wstrb_lo_q <= 1'h0;
            bvalid <= 1'h0;
            bresp <= RESP_OKAY;
        end
        else
        begin
            if (awvalid & awready)
            begin
                awaddr_q <= awaddr;
                aw_held <= 1'h1;
                awready <= 1'h0;
            end
            if (wvalid & wready)
            begin
                wdata_q <= wdata;
                wstrb_lo_q <= wstrb[0];
                w_held <= 1'h1;
                wready <= 1'h0;
            end
            if (do_write)
            begin
                aw_held <= 1'h0;
                w_held <= 1'h0;
                bvalid <= 1'h1;
                bresp <= wr_resp;
            end
            // readies come back only once the response is taken: one write at a time
            if (bvalid & bready)
            begin
                bvalid <= 1'h0;
                awready <= 1'h1;
                wready <= 1'h1;
            end
        end
    end

    // reads answer one cycle after the address is taken
    // arready stays low while data waits, so reads never overlap
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'h1;
            rvalid <= 1'h0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end
        else if (rd_take)
        begin
            arready <= 1'h0;
            rvalid <= 1'h1;
            rdata <= {24'h000000, rd_view};
            rresp <= rd_resp;
        end
        else if (rvalid & rready)
        begin
            rvalid <= 1'h0;
            arready <= 1'h1;
        end
    end

    // control and status registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pll_power_on <= PLL_POWER_ON_RESET;
            base_clock_select <= 1'h0;
            lock_irq_enable <= 1'h0;
            lock_change_flag <= 1'h0;
            auto_bandwidth <= 1'h0;
            lock_q <= 1'h0;
            prescale_exponent <= EXPONENT_RESET;
            vco_range_exponent <= EXPONENT_RESET;
            vco_linear_multiplier <= VCO_LINEAR_MULTIPLIER_RESET;
        end
        else
        begin
            pll_power_on <= next_power;
            base_clock_select <= next_select;
            lock_irq_enable <= next_irq_enable;
            lock_change_flag <= next_flag;
            lock_q <= lock_detect;
            if (wr_bw)
                auto_bandwidth <= wdata_q[BIT_AUTO_BANDWIDTH];
            if (wr_ctl & ~pll_power_on)
            begin
                // range settings only move while the loop is off
                prescale_exponent <= wdata_q[BIT_PRESCALE_EXPONENT_LO +: 2];
                vco_range_exponent <= wdata_q[BIT_VCO_RANGE_EXPONENT_LO +: 2];
            end
            if (wr_mul)
                vco_linear_multiplier <= wdata_q[7:0];
        end
    end

    // pin outputs, one register stage each
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pll_ref_clock <= 1'h0;
            pll_enable <= 1'h0;
            pll_irq <= 1'h0;
        end
        else
        begin
            pll_ref_clock <= osc_clock;
            // the loop only runs with a usable multiplier, whatever the power bit says
            pll_enable <= pll_power_on & ~multiplier_zero;
            // level: drops once a read clears the flag or enable goes away
            pll_irq <= lock_change_flag & lock_irq_enable & auto_bandwidth;
        end
    end

endmodule // base_clock_select_pll_control

`default_nettype wire

// ==== clock_gen_pkg.sv ====
`default_nettype none

package clock_gen_pkg;

    // register byte addresses on the bus
    localparam logic [31:0] ADDR_PLL_CONTROL = 32'h0000_0000;
    localparam logic [31:0] ADDR_BANDWIDTH_CONTROL = 32'h0000_0004;
    localparam logic [31:0] ADDR_VCO_LINEAR_MULTIPLIER = 32'h0000_0008;

    // register selector produced by the address decoder
    localparam logic [1:0] SEL_PLL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_BANDWIDTH_CONTROL = 2'h1;
    localparam logic [1:0] SEL_VCO_LINEAR_MULTIPLIER = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h3;

    // pll_control fields
    localparam int BIT_LOCK_IRQ_ENABLE = 7;
    localparam int BIT_LOCK_CHANGE_FLAG = 6;
    localparam int BIT_PLL_POWER_ON = 5;
    localparam int BIT_BASE_CLOCK_SELECT = 4;
    localparam int BIT_PRESCALE_EXPONENT_LO = 2;
    localparam int BIT_VCO_RANGE_EXPONENT_LO = 0;

    // bandwidth_control fields
    localparam int BIT_AUTO_BANDWIDTH = 7;
    localparam int BIT_LOCK_INDICATOR = 6;

    // reset values
    localparam logic PLL_POWER_ON_RESET = 1'h1;
    localparam logic [1:0] EXPONENT_RESET = 2'h0;
    localparam logic [7:0] VCO_LINEAR_MULTIPLIER_RESET = 8'h40;

    // source edges (both directions) per half period of each divided clock
    localparam int OSC_DIV_EDGES = 2;
    localparam int VCO_DIV_EDGES = 3;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// ==== clock_edge_divider.sv ====
`default_nettype none

// divides a sampled source clock by EDGES with 50 percent duty:
// every edge of the source counts, so odd ratios stay symmetric
module clock_edge_divider
    import clock_gen_pkg::*;
#(
    parameter int EDGES = 2
)
(
    // system
    input wire logic aclk,
    input wire logic aresetn,
    // source clock level, sampled on aclk
    input wire logic src_clock,
    // divided clock
    output logic div_clock
);

    logic src_q;
    logic [1:0] edge_count;
    wire logic src_edge = src_clock ^ src_q;
    wire logic last_edge = (edge_count == 2'(EDGES - 1));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            src_q <= 1'h0;
            edge_count <= 2'h0;
            div_clock <= 1'h0;
        end
        else
        begin
            src_q <= src_clock;
            if (src_edge)
            begin
                edge_count <= last_edge ? 2'h0 : edge_count + 2'h1;
                div_clock <= last_edge ? ~div_clock : div_clock;
            end
        end
    end

endmodule // clock_edge_divider

`default_nettype wire

// ==== base_clock_switch.sv ====
`default_nettype none

// glitch-free change of base clock source: the output freezes at its
// present level and is handed over only once the new divided clock
// shows the same level, so no runt pulse reaches the clock generator
module base_clock_switch
    import clock_gen_pkg::*;
(
    // system
    input wire logic aclk,
    input wire logic aresetn,
    // requested source, 1 = divided vco
    input wire logic select_vco,
    // divided sources
    input wire logic osc_div,
    input wire logic vco_div,
    // output
    output logic clock_out,
    output logic busy
);

    typedef enum logic {RUN, HOLD} switch_state_t;

    switch_state_t state;
    logic current_vco;
    wire logic target_div = select_vco ? vco_div : osc_div;
    wire logic current_div = current_vco ? vco_div : osc_div;
    wire logic match = (target_div == clock_out);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= RUN;
            current_vco <= 1'h0;
            clock_out <= 1'h0;
            busy <= 1'h0;
        end
        else
        begin
            unique case (state)
                RUN:
                begin
                    if (select_vco != current_vco)
                    begin
                        state <= HOLD;
                        busy <= 1'h1;
                    end
                    else
                    begin
                        clock_out <= current_div;
                    end
                end
                HOLD:
                begin
                    // output stays static until the new source lines up
                    if (match)
                    begin
                        state <= RUN;
                        current_vco <= select_vco;
                        busy <= 1'h0;
                    end
                end
            endcase
        end
    end

endmodule // base_clock_switch

`default_nettype wire

// ==== sys_clock_model.sv ====
`default_nettype none

// system clock generator side: measures the high and low run lengths of
// the base clock in aclk cycles; a run stretched by a source change is
// reported too, so measure only after the switch has settled
module sys_clock_model
(
    // system
    input wire logic aclk,
    // base clock from the selector
    input wire logic base_clock,
    // last measured runs
    output var int high_len,
    output var int low_len
);
    timeunit 1ns;
    timeprecision 100ps;
    int run = 0;
    logic last = 1'b0;

    always @(posedge aclk)
    begin
        last <= base_clock;
        run <= (base_clock == last) ? run + 1 : 1;
        if (base_clock != last && last)
            high_len <= run;
        if (base_clock != last && !last)
            low_len <= run;
    end
endmodule // sys_clock_model

`default_nettype wire

// ==== clock_ctl_checker.sv ====
`default_nettype none

module clock_ctl_checker
    import clock_gen_pkg::*;
(
    // system
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    // clock side
    input wire logic osc_clock,
    input wire logic lock_detect,
    input wire logic base_clock_out,
    input wire logic pll_ref_clock,
    input wire logic switch_busy,
    input wire logic pll_irq,
    input wire logic pll_enable,
    input wire logic [1:0] prescale_exponent,
    input wire logic [1:0] vco_range_exponent,
    input wire logic [7:0] vco_linear_multiplier
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence w_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence b_due;
        !awready && !wready ##1 bvalid;
    endsequence
    // lock must stay quiet around the read, else a new toggle rightly wins
    sequence ctl_read_quiet;
        arvalid && arready && araddr == ADDR_PLL_CONTROL && $past(lock_detect, 3) == lock_detect
        ##1 $stable(lock_detect) [*5];
    endsequence

    write_answer_a: assert property (w_taken |=> b_due)
        else $error("write response not on time");
    read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read data not on time");
    ref_follow_a: assert property ($past(aresetn) |-> pll_ref_clock == $past(osc_clock))
        else $error("reference clock not a copy of oscillator");
    switch_hold_a: assert property (switch_busy && $past(switch_busy) |-> $stable(base_clock_out))
        else $error("base clock moved during switch");
    switch_bound_a: assert property ($rose(switch_busy) |-> ##[1:48] !switch_busy)
        else $error("source switch too long");
    fields_locked_a: assert property (pll_enable |-> $stable(prescale_exponent)
        && $stable(vco_range_exponent) && $stable(vco_linear_multiplier))
        else $error("loop settings changed while running");
    zero_mult_a: assert property (vco_linear_multiplier == 8'h00 |=> !pll_enable)
        else $error("loop enabled with zero multiplier");
    irq_clear_a: assert property (ctl_read_quiet |-> !pll_irq)
        else $error("interrupt kept after control read");
endmodule // clock_ctl_checker

bind base_clock_select_pll_control clock_ctl_checker clock_ctl_checker_inst (.*);

`default_nettype wire

// ==== testbench.sv ====
`default_nettype none

module testbench
    import clock_gen_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, osc_clock, vco_clock, lock_detect;
    logic base_clock_out, pll_ref_clock, switch_busy, pll_irq, pll_enable;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [31:0] cnt = 32'h0;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, prescale_exponent, vco_range_exponent, r;
    logic [7:0] vco_linear_multiplier, d;
    int high_len, low_len, mismatches = 0, checks_done = 0;
    logic [7:0] wv [8] = '{8'h00, 8'h10, 8'h30, 8'h30, 8'h00, 8'h30, 8'h10, 8'h3f};
    logic [7:0] ev [8] = '{8'h00, 8'h00, 8'h20, 8'h30, 8'h20, 8'h30, 8'h30, 8'h30};

    base_clock_select_pll_control base_clock_select_pll_control_inst (.*);
    sys_clock_model sys_clock_model_inst (.aclk(aclk), .base_clock(base_clock_out),
        .high_len(high_len), .low_len(low_len));

    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // oscillator toggles every 4 cycles, vco every 3
    always @(posedge aclk)
    begin
        cnt <= cnt + 32'h1;
        osc_clock <= cnt[2];
        vco_clock <= (cnt % 6) < 3;
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", n, e, s);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] v);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            ad = ad | awready;
            wd = wd | wready;
            awvalid <= !ad;
            wvalid <= !wd;
        end
        do @(posedge aclk); while (!bvalid);
        chk("bresp", bresp, (a > ADDR_VCO_LINEAR_MULTIPLIER) ? RESP_SLVERR : RESP_OKAY);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rdc(input logic [31:0] a, input logic [7:0] e);
        rd(a);
        chk($sformatf("reg %0h", a), d, e);
        chk("rresp", r, RESP_OKAY);
    endtask

    task automatic wrc(input logic [31:0] a, input logic [7:0] v, input logic [7:0] e);
        wr(a, v);
        rdc(a, e);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #100000;
        mismatches++;
        results();
    end

    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, lock_detect} = '0;
        {awaddr, wdata, araddr} = '0;
        wstrb = 4'h1;
        aresetn = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(ADDR_PLL_CONTROL, 8'h20);
        rdc(ADDR_BANDWIDTH_CONTROL, 8'h00);
        rdc(ADDR_VCO_LINEAR_MULTIPLIER, 8'h40);
        rd(32'h0000_000c);
        chk("unmapped resp", r, RESP_SLVERR);
        chk("unmapped data", d, 8'h00);
        wr(32'h0000_000c, 8'hff);
        wstrb <= 4'h0;
        wrc(ADDR_PLL_CONTROL, 8'h00, 8'h20);
        wstrb <= 4'h1;
        $display("test reset done");
        for (int i = 0; i < 8; i++)
            wrc(ADDR_PLL_CONTROL, wv[i], ev[i]);
        repeat (80) @(posedge aclk);
        chk("vco high", high_len, 9);
        chk("vco low", low_len, 9);
        wr(ADDR_PLL_CONTROL, 8'h20);
        repeat (80) @(posedge aclk);
        chk("osc high", high_len, 8);
        chk("osc low", low_len, 8);
        $display("test interlock and source done");
        wr(ADDR_PLL_CONTROL, 8'h00);
        for (int p = 0; p < 4; p++)
        begin
            wrc(ADDR_PLL_CONTROL, 8'(p * 4 + p % 3), 8'(p * 4 + p % 3));
            chk("prescale", prescale_exponent, p);
            chk("range", vco_range_exponent, p % 3);
        end
        wrc(ADDR_VCO_LINEAR_MULTIPLIER, 8'h00, 8'h00);
        wrc(ADDR_PLL_CONTROL, 8'h20, 8'h20);
        wrc(ADDR_PLL_CONTROL, 8'h30, 8'h20);
        chk("enable zero mult", pll_enable, 1'b0);
        wrc(ADDR_PLL_CONTROL, 8'h00, 8'h00);
        wrc(ADDR_VCO_LINEAR_MULTIPLIER, 8'h40, 8'h40);
        wrc(ADDR_PLL_CONTROL, 8'h20, 8'h20);
        chk("enable", pll_enable, 1'b1);
        wrc(ADDR_VCO_LINEAR_MULTIPLIER, 8'h00, 8'h40);
        $display("test fields done");
        wrc(ADDR_PLL_CONTROL, 8'ha0, 8'h20);
        lock_detect <= 1'b1;
        repeat (4) @(posedge aclk);
        rdc(ADDR_PLL_CONTROL, 8'h20);
        chk("irq manual", pll_irq, 1'b0);
        wrc(ADDR_BANDWIDTH_CONTROL, 8'h80, 8'hc0);
        wrc(ADDR_PLL_CONTROL, 8'ha0, 8'ha0);
        repeat (2)
        begin
            lock_detect <= !lock_detect;
            repeat (6) @(posedge aclk);
            chk("irq", pll_irq, 1'b1);
            repeat (20) @(posedge aclk);
            chk("irq held", pll_irq, 1'b1);
            rdc(ADDR_PLL_CONTROL, 8'he0);
            repeat (4) @(posedge aclk);
            chk("irq cleared", pll_irq, 1'b0);
            rdc(ADDR_PLL_CONTROL, 8'ha0);
        end
        wrc(ADDR_BANDWIDTH_CONTROL, 8'h00, 8'h00);
        lock_detect <= !lock_detect;
        repeat (6) @(posedge aclk);
        chk("irq off", pll_irq, 1'b0);
        rdc(ADDR_PLL_CONTROL, 8'h20);
        $display("test lock flag done");
        results();
    end
endmodule // testbench

`default_nettype wire
